// ==== irq_combiner.sv ====
// Splits context interrupts by security and ORs the combined lines
`timescale 1ns/1ps
module irq_combiner import sb_irq_pkg::*; #(
   parameter int NUM_TBU = 2,
   parameter int NUM_CTX = 8
) (
   // Individual interrupt levels
   input wire logic gfault_s_i,
   input wire logic gfault_ns_i,
   input wire logic [NUM_TBU-1:0] perf_i,
   input wire logic [NUM_CTX-1:0] ctx_i,
   // Number of contexts owned by the non-secure side
   input wire logic [CNT_W-1:0] ns_count_i,
   // Combined lines
   output logic comb_ns_o,
   output logic comb_s_o
);
   logic [NUM_CTX-1:0] ns_mask;

   // Context below the split count belongs to the non-secure side
   for (genvar i = 0; i < NUM_CTX; i++) begin : g_mask
      assign ns_mask[i] = (CNT_W'(i) < ns_count_i);
   end

   // Pure OR so the combined lines follow their sources in the same cycle
   assign comb_ns_o = gfault_ns_i || (|perf_i) || (|(ctx_i & ns_mask));
   assign comb_s_o = gfault_s_i || (|(ctx_i & ~ns_mask));
endmodule // irq_combiner

// ==== sb_irq_pkg.sv ====
// Shared constants and carrier types for the sideband, interrupt and event block
package sb_irq_pkg;
   localparam int SSD_W = 10;
   localparam int SID_MAX_W = 15;
   localparam int CNT_W = 8;
   localparam int CLK_DIV_COUNT = 64;
   localparam int QOS_W = 4;
   // APB register byte offsets
   localparam logic [11:0] CFG_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] QOS_OFS = 12'h008;
   localparam logic [11:0] INTEG_OFS = 12'h00C;
   localparam logic [11:0] CAPTURE_OFS = 12'h010;
   // Field positions and reset values
   localparam int TOTAL_CTX_LSB = 8;
   localparam int INTEG_EN_BIT = 0;
   localparam int INTEG_GS_BIT = 1;
   localparam int INTEG_GNS_BIT = 2;
   localparam int INTEG_PERF_BIT = 3;
   localparam logic [3:0] INTEG_RESET = 4'h0;
   localparam logic [CNT_W-1:0] NS_COUNT_RESET = 8'h00;
   // Per-transaction sideband carried beside a valid
   typedef struct packed {
      logic ns;
      logic barrier;
      logic [SSD_W-1:0] ssd;
      logic [SID_MAX_W-1:0] sid;
   } sideband_t;
   // Per-unit performance event pulses
   typedef struct packed {
      logic clk;
      logic clk_div;
      logic wr_access;
      logic rd_access;
      logic wr_refill;
      logic rd_refill;
   } event_t;
endpackage

// ==== sb_irq_top.sv ====
// Sideband capture, interrupt outputs, tie-offs and event pulses with APB access
// Summary of operation
// - Read security bit taken with read valid
// - Write security bit taken with write valid
// - Domain index only without security bits
// - Stream IDs 1 to 15 bits per direction
// - Secure and non-secure global fault interrupts
// - One performance interrupt per translation unit
// - One interrupt per implemented context
// - Non-secure combined is OR of its sources
// - Secure combined is OR of secure global fault and upper contexts
// - Secure events counted only with debug enable
// - Coherent walk strap fixed after reset
// - Test enable bypasses clock gates
// - Override lets non-secure reach integration registers
// - Barrier disable means no barriers seen
// - Clock event every unit cycle
// - Divided clock event every 64th cycle
// - Access event per read and write
// - Refill event per cache allocation
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module sb_irq_top import sb_irq_pkg::*; #(
   parameter int NUM_TBU = 2,
   parameter int NUM_CTX = 8,
   parameter int SID_W = 15,
   parameter bit HAS_NS = 1'b1
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic reset_n_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [2:0] pprot_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Per-unit address channels and sidebands
   input wire logic [NUM_TBU-1:0] rd_valid_i,
   input wire logic [NUM_TBU-1:0] rd_ready_i,
   input sideband_t [NUM_TBU-1:0] rd_side_i,
   input wire logic [NUM_TBU-1:0] wr_valid_i,
   input wire logic [NUM_TBU-1:0] wr_ready_i,
   input sideband_t [NUM_TBU-1:0] wr_side_i,
   input wire logic [NUM_TBU-1:0] barrier_disable_i,
   output sideband_t [NUM_TBU-1:0] rd_side_o,
   output sideband_t [NUM_TBU-1:0] wr_side_o,
   // Translation cache allocations
   input wire logic [NUM_TBU-1:0] rd_refill_i,
   input wire logic [NUM_TBU-1:0] rd_refill_ns_i,
   input wire logic [NUM_TBU-1:0] wr_refill_i,
   input wire logic [NUM_TBU-1:0] wr_refill_ns_i,
   // Interrupt sources
   input wire logic gfault_s_i,
   input wire logic gfault_ns_i,
   input wire logic [NUM_TBU-1:0] perf_ovf_i,
   input wire logic [NUM_CTX-1:0] ctx_fault_i,
   // Interrupt outputs
   output logic global_fault_irq_secure_o,
   output logic global_fault_irq_nonsecure_o,
   output logic [NUM_TBU-1:0] perf_irq_o,
   output logic [NUM_CTX-1:0] ctx_irq_o,
   output logic combined_irq_nonsecure_o,
   output logic combined_irq_secure_o,
   // Debug and tie-offs
   input wire logic secure_debug_en_i,
   input wire logic [QOS_W-1:0] qos_arb_i,
   input wire logic coherent_walk_cfg_i,
   input wire logic test_clk_enable_i,
   input wire logic integ_override_i,
   input wire logic clk_gate_req_i,
   output logic coherent_walk_o,
   output logic clk_gate_en_o,
   // Performance events
   output event_t [NUM_TBU-1:0] evt_o
);
   logic rst_meta;
   logic rst_n;
   logic cttw_taken;
   logic [CNT_W-1:0] nonsecure_context_count_field;
   logic [CNT_W-1:0] total_context_banks_field;
   logic [3:0] integ;
   logic [QOS_W-1:0] qos_q;
   logic apb_acc;
   logic apb_wr;
   logic integ_denied;
   logic hit;
   logic [31:0] next_rdata;
   logic [NUM_TBU-1:0] rd_take;
   logic [NUM_TBU-1:0] wr_take;
   logic [SID_MAX_W-1:0] sid_mask;

   if (NUM_TBU < 1 || NUM_CTX < 1 || NUM_CTX > 255 || SID_W < 1 || SID_W > SID_MAX_W) begin
      : g_bad_cfg
      $error("Unsupported unit, context or stream ID width");
   end

   assign total_context_banks_field = CNT_W'(NUM_CTX);
   assign sid_mask = SID_MAX_W'((1 << SID_W) - 1);

   // Reset release through two flops, assertion stays asynchronous
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n <= rst_meta;
      end
   end

   // Coherent walk strap caught once after release, never again
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         cttw_taken <= 1'b0;
         coherent_walk_o <= 1'b0;
      end else if (!cttw_taken) begin
         cttw_taken <= 1'b1;
         coherent_walk_o <= coherent_walk_cfg_i;
      end
   end

   // Test mode forces gate open whatever the functional request
   assign clk_gate_en_o = test_clk_enable_i || clk_gate_req_i;

   // Sideband capture per unit on each accepted address
   for (genvar t = 0; t < NUM_TBU; t++) begin : g_tbu
      assign rd_take[t] = rd_valid_i[t] && rd_ready_i[t];
      assign wr_take[t] = wr_valid_i[t] && wr_ready_i[t];

      // Without security bits the domain index carries security instead
      always_ff @(posedge clock_i or negedge rst_n) begin
         if (!rst_n) begin
            rd_side_o[t] <= '0;
         end else if (rd_take[t]) begin
            rd_side_o[t].ns <= HAS_NS ? rd_side_i[t].ns : (rd_side_i[t].ssd != '0);
            rd_side_o[t].ssd <= HAS_NS ? '0 : rd_side_i[t].ssd;
            rd_side_o[t].sid <= rd_side_i[t].sid & sid_mask;
            rd_side_o[t].barrier <= rd_side_i[t].barrier && !barrier_disable_i[t];
         end
      end

      always_ff @(posedge clock_i or negedge rst_n) begin
         if (!rst_n) begin
            wr_side_o[t] <= '0;
         end else if (wr_take[t]) begin
            wr_side_o[t].ns <= HAS_NS ? wr_side_i[t].ns : (wr_side_i[t].ssd != '0);
            wr_side_o[t].ssd <= HAS_NS ? '0 : wr_side_i[t].ssd;
            wr_side_o[t].sid <= wr_side_i[t].sid & sid_mask;
            wr_side_o[t].barrier <= wr_side_i[t].barrier && !barrier_disable_i[t];
         end
      end

      tbu_event_gen #(.DIV(CLK_DIV_COUNT)) u_evt (
         .clock_i(clock_i),
         .rst_n_i(rst_n),
         .rd_take_i(rd_take[t]),
         .rd_ns_i(HAS_NS ? rd_side_i[t].ns : (rd_side_i[t].ssd != '0)),
         .wr_take_i(wr_take[t]),
         .wr_ns_i(HAS_NS ? wr_side_i[t].ns : (wr_side_i[t].ssd != '0)),
         .rd_refill_i(rd_refill_i[t]),
         .rd_refill_ns_i(rd_refill_ns_i[t]),
         .wr_refill_i(wr_refill_i[t]),
         .wr_refill_ns_i(wr_refill_ns_i[t]),
         .secure_count_i(secure_debug_en_i),
         .evt_o(evt_o[t])
      );
   end

   // Interrupt levels registered; integration mode drives global fault and perf levels from software, context levels low
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         global_fault_irq_secure_o <= 1'b0;
         global_fault_irq_nonsecure_o <= 1'b0;
         perf_irq_o <= '0;
         ctx_irq_o <= '0;
      end else if (integ[INTEG_EN_BIT]) begin
         global_fault_irq_secure_o <= integ[INTEG_GS_BIT];
         global_fault_irq_nonsecure_o <= integ[INTEG_GNS_BIT];
         perf_irq_o <= {NUM_TBU{integ[INTEG_PERF_BIT]}};
         ctx_irq_o <= '0;
      end else begin
         global_fault_irq_secure_o <= gfault_s_i;
         global_fault_irq_nonsecure_o <= gfault_ns_i;
         perf_irq_o <= perf_ovf_i;
         ctx_irq_o <= ctx_fault_i;
      end
   end

   irq_combiner #(.NUM_TBU(NUM_TBU), .NUM_CTX(NUM_CTX)) u_comb (
      .gfault_s_i(global_fault_irq_secure_o),
      .gfault_ns_i(global_fault_irq_nonsecure_o),
      .perf_i(perf_irq_o),
      .ctx_i(ctx_irq_o),
      .ns_count_i(nonsecure_context_count_field),
      .comb_ns_o(combined_irq_nonsecure_o),
      .comb_s_o(combined_irq_secure_o)
   );

   // APB decode: zero wait states, error on unmapped or refused access
   assign apb_acc = psel_i && penable_i;
   assign apb_wr = apb_acc && pwrite_i;
   assign integ_denied = (paddr_i == INTEG_OFS) && pprot_i[1] && !integ_override_i;
   assign pready_o = 1'b1;

   always_comb begin
      hit = 1'b1;
      next_rdata = 32'h0000_0000;
      if (paddr_i == CFG_OFS) begin
         next_rdata[CNT_W-1:0] = nonsecure_context_count_field;
         next_rdata[TOTAL_CTX_LSB +: CNT_W] = total_context_banks_field;
      end else if (paddr_i == STATUS_OFS) begin
         next_rdata[7:0] = {cttw_taken, coherent_walk_o, test_clk_enable_i,
            secure_debug_en_i, combined_irq_secure_o, combined_irq_nonsecure_o,
            global_fault_irq_secure_o, global_fault_irq_nonsecure_o};
      end else if (paddr_i == QOS_OFS) begin
         next_rdata[QOS_W-1:0] = qos_q;
      end else if (paddr_i == INTEG_OFS) begin
         next_rdata[3:0] = integ_denied ? 4'h0 : integ;
      end else if (paddr_i == CAPTURE_OFS) begin
         next_rdata[SID_MAX_W-1:0] = rd_side_o[0].sid;
         next_rdata[16 +: SSD_W] = rd_side_o[0].ssd;
         next_rdata[30] = rd_side_o[0].barrier;
         next_rdata[31] = rd_side_o[0].ns;
      end else begin
         hit = 1'b0;
      end
   end

   assign pslverr_o = apb_acc && (!hit || integ_denied);

   // Read data registered at the setup cycle so it is stable in the access phase
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= next_rdata;
      end
   end

   // Writable registers
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         nonsecure_context_count_field <= NS_COUNT_RESET;
         integ <= INTEG_RESET;
      end else if (apb_wr && paddr_i == CFG_OFS) begin
         nonsecure_context_count_field <= pwdata_i[CNT_W-1:0];
      end else if (apb_wr && paddr_i == INTEG_OFS && !integ_denied) begin
         integ <= pwdata_i[3:0];
      end
   end

   // Priority hint only observed for software
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         qos_q <= '0;
      end else begin
         qos_q <= qos_arb_i;
      end
   end

   // Gap since last divided pulse, read only by checks
   logic [7:0] div_gap;
   logic div_seen;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         div_gap <= 8'h00;
         div_seen <= 1'b0;
      end else if (evt_o[0].clk_div) begin
         div_gap <= 8'h00;
         div_seen <= 1'b1;
      end else begin
         div_gap <= div_gap + 8'h01;
      end
   end

   a_rd_ns_capture: assert property (@(posedge clock_i) disable iff (!rst_n)
      (HAS_NS && rd_take[0]) |=> rd_side_o[0].ns == $past(rd_side_i[0].ns))
      else $error("read security not captured");
   a_wr_ns_capture: assert property (@(posedge clock_i) disable iff (!rst_n)
      (HAS_NS && wr_take[0]) |=> wr_side_o[0].ns == $past(wr_side_i[0].ns))
      else $error("write security not captured");
   a_ssd_absent: assert property (@(posedge clock_i) disable iff (!rst_n)
      HAS_NS |-> (rd_side_o[0].ssd == '0 && wr_side_o[0].ssd == '0))
      else $error("domain index present with security bits");
   a_sid_width: assert property (@(posedge clock_i) disable iff (!rst_n)
      rd_take[0] |=> rd_side_o[0].sid == ($past(rd_side_i[0].sid) & sid_mask))
      else $error("stream ID not captured at width");
   a_gfault_follow: assert property (@(posedge clock_i) disable iff (!rst_n)
      !integ[INTEG_EN_BIT] |=> global_fault_irq_secure_o == $past(gfault_s_i))
      else $error("secure global fault not forwarded");
   a_comb_ns_or: assert property (@(posedge clock_i) disable iff (!rst_n)
      (global_fault_irq_nonsecure_o || (|perf_irq_o)) |-> combined_irq_nonsecure_o)
      else $error("non-secure combined missing a source");
   a_comb_s_split: assert property (@(posedge clock_i) disable iff (!rst_n)
      (!global_fault_irq_secure_o && nonsecure_context_count_field >= CNT_W'(NUM_CTX))
      |-> !combined_irq_secure_o)
      else $error("secure combined raised by non-secure context");
   a_secure_gate: assert property (@(posedge clock_i) disable iff (!rst_n)
      (rd_take[0] && HAS_NS && !rd_side_i[0].ns && !secure_debug_en_i) |=> !evt_o[0].rd_access)
      else $error("secure read counted without debug enable");
   a_cttw_stable: assert property (@(posedge clock_i) disable iff (!rst_n)
      $past(cttw_taken) |-> $stable(coherent_walk_o))
      else $error("coherent walk setting changed");
   a_gate_bypass: assert property (@(posedge clock_i) disable iff (!rst_n)
      test_clk_enable_i |-> clk_gate_en_o)
      else $error("clock gate not bypassed in test");
   a_integ_refuse: assert property (@(posedge clock_i) disable iff (!rst_n)
      (apb_wr && integ_denied) |=> $stable(integ))
      else $error("refused integration write took effect");
   a_barrier_mask: assert property (@(posedge clock_i) disable iff (!rst_n)
      (rd_take[0] && barrier_disable_i[0]) |=> !rd_side_o[0].barrier)
      else $error("barrier seen with barriers disabled");
   a_clk_event: assert property (@(posedge clock_i) disable iff (!rst_n)
      $past(rst_n) |-> evt_o[0].clk)
      else $error("clock event missing");
   a_clk_div_gap: assert property (@(posedge clock_i) disable iff (!rst_n)
      (evt_o[0].clk_div && div_seen) |-> div_gap == 8'(CLK_DIV_COUNT - 1))
      else $error("divided clock event spacing wrong");
   a_access_pulse: assert property (@(posedge clock_i) disable iff (!rst_n)
      (wr_take[0] && (wr_side_i[0].ns || secure_debug_en_i) && !HAS_NS == 1'b0)
      |=> evt_o[0].wr_access)
      else $error("write access event missing");
   a_refill_pulse: assert property (@(posedge clock_i) disable iff (!rst_n)
      (rd_refill_i[0] && rd_refill_ns_i[0]) |=> evt_o[0].rd_refill)
      else $error("read refill event missing");

   c_secure_read: cover property (@(posedge clock_i) disable iff (!rst_n)
      rd_take[0] && !rd_side_i[0].ns && secure_debug_en_i ##1 evt_o[0].rd_access);
   c_comb_both: cover property (@(posedge clock_i) disable iff (!rst_n)
      combined_irq_secure_o && combined_irq_nonsecure_o);
   c_integ_refused: cover property (@(posedge clock_i) disable iff (!rst_n)
      apb_wr && integ_denied);
endmodule // sb_irq_top

// ==== smmu_sideband_irq_event_signals_test.sv ====
// Self-checking bench for sideband capture, interrupts, tie-offs and events
`timescale 1ns/1ps
module smmu_sideband_irq_event_signals_test import sb_irq_pkg::*;;
   logic clock_i, reset_n_i, psel, penable, pwrite, dbg, tclk, iovr, cgreq;
   logic gf_s, gf_ns, gfo_s, gfo_ns, cmb_ns, cmb_s, cw, cge, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] pprot;
   logic [3:0] qos;
   logic [1:0] rd_v, rd_r, wr_v, wr_r, rf_r, rf_rns, rf_w, rf_wns, perf, perf_o;
   logic [7:0] ctx, ctx_o;
   sideband_t [1:0] rd_s, wr_s, rd_so, wr_so;
   event_t [1:0] evt;
   logic [33:0] exp_q[$];
   logic [33:0] ent;
   logic [31:0] seed = 32'h3E74;
   int err_count = 0;
   int n_compared = 0;
   localparam logic [1:0] BAR_DIS = 2'h1;

   // Free-running 100 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   sb_irq_top #(.NUM_TBU(2), .NUM_CTX(8), .SID_W(15), .HAS_NS(1'b1)) dut_u (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pprot_i(pprot),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rd_valid_i(rd_v),
      .rd_ready_i(rd_r), .rd_side_i(rd_s), .wr_valid_i(wr_v), .wr_ready_i(wr_r),
      .wr_side_i(wr_s), .barrier_disable_i(BAR_DIS), .rd_side_o(rd_so), .wr_side_o(wr_so),
      .rd_refill_i(rf_r), .rd_refill_ns_i(rf_rns), .wr_refill_i(rf_w),
      .wr_refill_ns_i(rf_wns), .gfault_s_i(gf_s), .gfault_ns_i(gf_ns), .perf_ovf_i(perf),
      .ctx_fault_i(ctx), .global_fault_irq_secure_o(gfo_s),
      .global_fault_irq_nonsecure_o(gfo_ns), .perf_irq_o(perf_o), .ctx_irq_o(ctx_o),
      .combined_irq_nonsecure_o(cmb_ns), .combined_irq_secure_o(cmb_s),
      .secure_debug_en_i(dbg), .qos_arb_i(qos), .coherent_walk_cfg_i(1'b1),
      .test_clk_enable_i(tclk), .integ_override_i(iovr), .clk_gate_req_i(cgreq),
      .coherent_walk_o(cw), .clk_gate_en_o(cge), .evt_o(evt));

   txn_source src_u (.clock_i(clock_i), .rd_valid_o(rd_v), .rd_ready_o(rd_r),
      .rd_side_o(rd_s), .wr_valid_o(wr_v), .wr_ready_o(wr_r), .wr_side_o(wr_s));

   // Xorshift source, fixed seed for repeatable runs
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask

   // One APB transfer; the expected answer is queued for the monitor
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [2:0] pr, input logic er);
      exp_q.push_back({w, er, d});
      {psel, penable, pwrite} <= {2'b10, w};
      paddr <= a;
      pwdata <= d;
      pprot <= pr;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready !== 1'b1) @(posedge clock_i);
      {psel, penable} <= 2'b00;
      @(posedge clock_i);
   endtask

   // Completion monitor takes the oldest note at each finished access
   always @(posedge clock_i) begin
      if (psel && penable && pready === 1'b1) begin
         ent = exp_q.pop_front();
         chk("pslverr", {31'h0, ent[32]}, {31'h0, pslverr});
         if (!ent[33]) chk("prdata", ent[31:0], prdata);
      end
   end

   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Watchdog against a hung wait
   initial begin
      #200000;
      err_count++;
      finish_test();
   end

   initial begin
      int i, k, n, t, u;
      logic [31:0] r;
      logic [7:0] m;
      logic w, ns;
      sideband_t s, e;
      {psel, penable, pwrite, dbg, tclk, iovr, cgreq, gf_s, gf_ns} = '0;
      {paddr, pwdata, pprot, qos, ctx} = '0;
      {rf_r, rf_rns, rf_w, rf_wns, perf} = '0;
      reset_n_i = 1'b0;
      repeat (2) @(posedge clock_i);
      reset_n_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      #1;
      chk("coherent_walk", 32'h1, cw);
      @(posedge clock_i);
      // Reset values, unmapped place and priority input
      r = rnd();
      qos <= r[3:0];
      apb(1'b0, CFG_OFS, 32'h0000_0800, 3'h0, 1'b0);
      apb(1'b0, INTEG_OFS, 32'h0, 3'h0, 1'b0);
      apb(1'b0, 12'h020, 32'h0, 3'h0, 1'b1);
      apb(1'b0, QOS_OFS, {28'h0, r[3:0]}, 3'h0, 1'b0);
      $display("test registers done");
      // Context split at non-secure count boundaries 0 and 8 and random ones
      for (i = 0; i < 6; i++) begin
         n = (i == 0) ? 0 : (i == 1) ? 8 : rnd() % 9;
         apb(1'b1, CFG_OFS, n, 3'h0, 1'b0);
         apb(1'b0, CFG_OFS, 32'h0800 | n, 3'h0, 1'b0);
         r = rnd();
         {gf_s, gf_ns, perf, ctx} <= r[11:0];
         @(posedge clock_i);
         #1;
         m = 8'hFF >> (8 - n);
         chk("ctx_irq", ctx, ctx_o);
         chk("perf_irq", perf, perf_o);
         chk("gfault", {gf_s, gf_ns}, {gfo_s, gfo_ns});
         chk("comb_ns", gf_ns | (|perf) | (|(ctx & m)), cmb_ns);
         chk("comb_s", gf_s | (|(ctx & ~m)), cmb_s);
         @(posedge clock_i);
      end
      {gf_s, gf_ns, perf, ctx} <= '0;
      $display("test interrupts done");
      // Integration place refused, then opened by the override
      apb(1'b1, INTEG_OFS, 32'h3, 3'h2, 1'b1);
      apb(1'b0, INTEG_OFS, 32'h0, 3'h2, 1'b1);
      iovr <= 1'b1;
      apb(1'b1, INTEG_OFS, 32'h3, 3'h2, 1'b0);
      apb(1'b0, INTEG_OFS, 32'h3, 3'h2, 1'b0);
      #1;
      chk("forced_gfault", 32'h3, {gfo_s, cmb_s});
      @(posedge clock_i);
      apb(1'b1, INTEG_OFS, 32'h0, 3'h0, 1'b0);
      iovr <= 1'b0;
      $display("test integration done");
      // Every unit, direction and security, each with debug gating off and on
      for (k = 0; k < 16; k++) begin
         u = k & 1;
         w = k[1];
         ns = k[2];
         r = rnd();
         dbg <= k[3];
         s = r[26:0];
         s.ns = ns;
         src_u.send(u, w, s, r[30:29]);
         #1;
         e = s;
         e.ssd = '0;
         e.barrier = s.barrier & ~BAR_DIS[u];
         chk("side_o", e, w ? wr_so[u] : rd_so[u]);
         chk("access_evt", {w, ~w} & {2{ns | dbg}}, {evt[u].wr_access, evt[u].rd_access});
         @(posedge clock_i);
         #1;
         chk("access_pulse", 32'h0, {evt[u].wr_access, evt[u].rd_access});
         @(posedge clock_i);
         rf_w <= w ? 2'h1 << u : 2'h0;
         rf_r <= w ? 2'h0 : 2'h1 << u;
         rf_wns <= {2{ns}};
         rf_rns <= {2{ns}};
         @(posedge clock_i);
         {rf_w, rf_r} <= '0;
         #1;
         chk("refill_evt", {w, ~w} & {2{ns | dbg}}, {evt[u].wr_refill, evt[u].rd_refill});
         @(posedge clock_i);
      end
      $display("test events done");
      // Divided clock period and per-cycle clock event; look off the edge
      #1;
      for (t = 0; t < 200 && evt[0].clk_div !== 1'b1; t++) begin
         @(posedge clock_i);
         #1;
      end
      t = 0;
      do begin
         @(posedge clock_i);
         #1;
         t++;
         chk("clk_evt", 32'h1, evt[1].clk);
      end while (evt[0].clk_div !== 1'b1 && t < 200);
      chk("clk_div_period", CLK_DIV_COUNT, t);
      $display("test clock events done");
      // Clock gate bypass for every test-enable and request pair
      for (k = 0; k < 4; k++) begin
         @(posedge clock_i);
         tclk <= k[0];
         cgreq <= k[1];
         @(posedge clock_i);
         #1;
         chk("clk_gate_en", k[0] | k[1], cge);
      end
      $display("test clock gate done");
      @(posedge clock_i);
      finish_test();
   end
endmodule // smmu_sideband_irq_event_signals_test

// ==== tbu_event_gen.sv ====
// Performance event pulse generator for one translation unit
`timescale 1ns/1ps
module tbu_event_gen import sb_irq_pkg::*; #(
   parameter int DIV = CLK_DIV_COUNT
) (
   // Clock and synchronised reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Accepted transactions and cache allocations
   input wire logic rd_take_i,
   input wire logic rd_ns_i,
   input wire logic wr_take_i,
   input wire logic wr_ns_i,
   input wire logic rd_refill_i,
   input wire logic rd_refill_ns_i,
   input wire logic wr_refill_i,
   input wire logic wr_refill_ns_i,
   // Secure counting permitted
   input wire logic secure_count_i,
   // Event pulses
   output event_t evt_o
);
   localparam int DW = $clog2(DIV);
   logic [DW-1:0] div_cnt;

   if (DIV < 2) begin : g_bad_div
      $error("DIV must be at least 2");
   end

   // Free-running divider, pulse on its last count
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_cnt <= '0;
      end else if (div_cnt == DW'(DIV - 1)) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= div_cnt + 1'b1;
      end
   end

   // One registered pulse per occurrence; secure ones only when allowed
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         evt_o <= '0;
      end else begin
         evt_o.clk <= 1'b1;
         evt_o.clk_div <= (div_cnt == DW'(DIV - 1));
         evt_o.rd_access <= rd_take_i && (rd_ns_i || secure_count_i);
         evt_o.wr_access <= wr_take_i && (wr_ns_i || secure_count_i);
         evt_o.rd_refill <= rd_refill_i && (rd_refill_ns_i || secure_count_i);
         evt_o.wr_refill <= wr_refill_i && (wr_refill_ns_i || secure_count_i);
      end
   end
endmodule // tbu_event_gen

// ==== txn_source.sv ====
// Behavioural upstream master driving address valids with their sidebands
`timescale 1ns/1ps
module txn_source import sb_irq_pkg::*; (
   // Clock
   input wire logic clock_i,
   // Address channels toward the block
   output logic [1:0] rd_valid_o,
   output logic [1:0] rd_ready_o,
   output sideband_t [1:0] rd_side_o,
   output logic [1:0] wr_valid_o,
   output logic [1:0] wr_ready_o,
   output sideband_t [1:0] wr_side_o
);
   // Idle channels from time zero
   initial begin
      {rd_valid_o, rd_ready_o, wr_valid_o, wr_ready_o} = '0;
      rd_side_o = '0;
      wr_side_o = '0;
   end
   // Sideband stands with valid until the take edge
   task automatic send(input int u, input logic w, input sideband_t s, input int stall);
      if (w) begin
         wr_valid_o[u] <= 1'b1;
         wr_side_o[u] <= s;
      end else begin
         rd_valid_o[u] <= 1'b1;
         rd_side_o[u] <= s;
      end
      // Downstream may hold off acceptance for a few cycles
      repeat (stall) @(posedge clock_i);
      if (w) wr_ready_o[u] <= 1'b1;
      else rd_ready_o[u] <= 1'b1;
      @(posedge clock_i);
      // Released lines show inverted data so a stale capture cannot pass
      if (w) begin
         {wr_valid_o[u], wr_ready_o[u]} <= 2'b00;
         wr_side_o[u] <= ~s;
      end else begin
         {rd_valid_o[u], rd_ready_o[u]} <= 2'b00;
         rd_side_o[u] <= ~s;
      end
   endtask
endmodule // txn_source
